// ### shared/ulm_pkg.sv
package ulm_pkg;

	// line-mode field codes
	localparam logic [3:0] ULM_MODE_NORMAL    = 4'h0;
	localparam logic [3:0] ULM_MODE_RS485     = 4'h1;
	localparam logic [3:0] ULM_MODE_HANDSHAKE = 4'h2;
	localparam logic [3:0] ULM_MODE_MODEM     = 4'h3;
	localparam logic [3:0] ULM_MODE_IRDA      = 4'h8;

	// channel routing, in field order 0..3
	typedef enum logic [1:0] {
		ULM_ROUTE_NORMAL,
		ULM_ROUTE_ECHO,
		ULM_ROUTE_LOCAL,
		ULM_ROUTE_REMOTE
	} ulm_route_type;

	// infrared filter phases
	typedef enum logic [1:0] {
		ULM_FILT_IDLE,
		ULM_FILT_COUNT,
		ULM_FILT_HOLD
	} ulm_filt_type;

	// widths
	localparam int ULM_FILTER_W = 8;
	localparam int ULM_BIT_W    = 16;
	localparam int ULM_MODEM_N  = 4;
	localparam int ULM_EVT_W    = 2 * ULM_MODEM_N;

	// modem input positions in the sampled vector
	localparam int ULM_IDX_CTS = 0;
	localparam int ULM_IDX_DCD = 1;
	localparam int ULM_IDX_DSR = 2;
	localparam int ULM_IDX_RI  = 3;

	// infrared pulse is 3/16 of a bit period
	localparam int ULM_IR_PULSE_NUM   = 3;
	localparam int ULM_IR_PULSE_SHIFT = 4;
	// allowed baud error in hundredths of a percent
	localparam int ULM_IR_BAUD_TOL_X100 = 187;

	// reset and idle levels, and the priming end count
	localparam logic       ULM_DTR_RST   = 1'b1;
	localparam logic       ULM_RTS_RST   = 1'b0;
	localparam logic       ULM_TXD_IDLE  = 1'b1;
	localparam logic       ULM_RXS_IDLE  = 1'b1;
	localparam logic [1:0] ULM_PRIME_END = 2'h3;

endpackage

// ### shared/ulm_stream_if.sv
`timescale 1ns/1ps
interface ulm_stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (
		output valid,
		output data,
		input  ready
	);
	modport snk (
		input  valid,
		input  data,
		output ready
	);
endinterface

// ### src/ulm_fifo2.sv
`timescale 1ns/1ps
module ulm_fifo2 #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	ulm_stream_if.snk in_s,
	ulm_stream_if.src out_s
);
	import ulm_pkg::*;

	typedef struct packed {
		logic [W-1:0] head;
		logic [W-1:0] tail;
		logic         hv;
		logic         tv;
	} ulm_fifo_state_type;

	ulm_fifo_state_type s_q;
	ulm_fifo_state_type s_d;
	logic               pop;
	logic               push;

	// head and ready come straight from flops
	assign out_s.valid = s_q.hv;
	assign out_s.data  = s_q.head;
	assign in_s.ready  = ~s_q.tv;

	always_comb begin
		s_d  = s_q;
		pop  = s_q.hv & out_s.ready;
		push = in_s.valid & ~s_q.tv;
		if (pop) begin
			if (s_q.tv) begin
				s_d.head = s_q.tail;
				s_d.tv   = 1'b0;
			end else begin
				s_d.hv = 1'b0;
			end
		end
		if (push) begin
			if (!s_d.hv) begin
				s_d.head = in_s.data;
				s_d.hv   = 1'b1;
			end else begin
				s_d.tail = in_s.data;
				s_d.tv   = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end
endmodule

// ### src/ulm_irda_filter.sv
`timescale 1ns/1ps
module ulm_irda_filter #(
	parameter int FILTER_W = 8,
	parameter int BIT_W    = 16
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                clk_en,
	input  wire logic                enable,
	input  wire logic                rx_pin,
	input  wire logic [FILTER_W-1:0] filter_load,
	input  wire logic [BIT_W-1:0]    bit_len,
	output logic                     demod_out
);
	import ulm_pkg::*;

	typedef struct packed {
		ulm_filt_type        phase;
		logic [FILTER_W-1:0] cnt;
		logic [BIT_W-1:0]    hold;
		logic                prev;
		logic                out;
	} ulm_filt_state_type;

	ulm_filt_state_type s_q;
	ulm_filt_state_type s_d;
	logic               fall;
	logic               rise;

	assign demod_out = s_q.out;

	always_comb begin
		s_d      = s_q;
		s_d.prev = rx_pin;
		fall     = s_q.prev & ~rx_pin;
		rise     = ~s_q.prev & rx_pin;
		if (!enable) begin
			s_d.phase = ULM_FILT_IDLE;
			s_d.cnt   = filter_load;
			s_d.out   = ULM_RXS_IDLE;
		end else begin
			unique case (s_q.phase)
				ULM_FILT_IDLE: begin
					s_d.cnt = filter_load;
					if (fall) begin
						s_d.phase = ULM_FILT_COUNT;
					end
				end
				ULM_FILT_COUNT: begin
					if (rise) begin
						s_d.phase = ULM_FILT_IDLE;
						s_d.cnt   = filter_load;
					end else if (s_q.cnt == '0) begin
						s_d.phase = ULM_FILT_HOLD;
						s_d.hold  = bit_len;
						s_d.out   = 1'b0;
					end else begin
						s_d.cnt = s_q.cnt - 1'b1;
					end
				end
				ULM_FILT_HOLD: begin
					if (s_q.hold <= BIT_W'(1)) begin
						s_d.phase = ULM_FILT_IDLE;
						s_d.cnt   = filter_load;
						s_d.out   = ULM_RXS_IDLE;
					end else begin
						s_d.hold = s_q.hold - 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q      <= '0;
			s_q.prev <= ULM_RXS_IDLE;
			s_q.out  <= ULM_RXS_IDLE;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end
endmodule

// ### src/ulm_line_modes.sv
`timescale 1ns/1ps
module ulm_line_modes #(
	parameter int FILTER_W = ulm_pkg::ULM_FILTER_W,
	parameter int BIT_W    = ulm_pkg::ULM_BIT_W
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                clk_en,
	input  wire logic [3:0]          line_mode,
	input  wire logic [1:0]          channel_routing_field,
	input  wire logic [FILTER_W-1:0] infrared_filter_setting,
	input  wire logic [BIT_W-1:0]    bit_period_cycles,
	input  wire logic                rxd_pin,
	output logic                     txd_pin,
	output logic                     rts_pin,
	output logic                     dtr_pin,
	input  wire logic                cts_pin,
	input  wire logic                dsr_pin,
	input  wire logic                dcd_pin,
	input  wire logic                ri_pin,
	input  wire logic                tx_serial,
	input  wire logic                transmitter_drained_flag,
	input  wire logic                timeguard_active,
	input  wire logic                char_in_progress,
	input  wire logic                core_rts_level,
	output logic                     rx_serial,
	output logic                     rx_enable,
	output logic                     tx_enable,
	output logic                     force_async,
	output logic                     infrared_active,
	input  wire logic                terminal_ready_on_command,
	input  wire logic                terminal_ready_off_command,
	input  wire logic                status_read,
	output logic                     ring_change_flag,
	output logic                     set_ready_change_flag,
	output logic                     carrier_change_flag,
	output logic                     clear_to_send_change_flag,
	output logic [3:0]               modem_levels,
	output logic                     evt_valid,
	output logic [ulm_pkg::ULM_EVT_W-1:0] evt_data,
	input  wire logic                evt_ready
);
	import ulm_pkg::*;

	typedef struct packed {
		logic [ULM_MODEM_N-1:0] sync1;
		logic [ULM_MODEM_N-1:0] sync2;
		logic [ULM_MODEM_N-1:0] prev;
		logic [1:0]             prime;
		logic [ULM_MODEM_N-1:0] flags;
		logic [ULM_MODEM_N-1:0] pend_chg;
		logic                   pend_v;
		logic                   dtr;
		logic                   rts;
		logic                   txd;
		logic                   rxs;
		logic                   rx_en;
		logic                   tx_en;
		logic                   cts_block;
		logic                   async;
		logic                   ir_on;
		logic [BIT_W-1:0]       phase;
		logic                   last_tx;
	} ulm_top_state_type;

	ulm_top_state_type      s_q;
	ulm_top_state_type      s_d;
	logic                   is_rs485;
	logic                   is_modem;
	logic                   is_irda;
	ulm_route_type          route;
	logic [ULM_MODEM_N-1:0] chg;
	logic                   primed;
	logic                   demod;
	logic                   rx_line;
	logic                   tx_line;
	logic                   tx_edge;
	logic [BIT_W-1:0]       ph;
	logic [BIT_W+1:0]       pulse_len;
	logic                   pulse;
	logic                   evt_in_ready;

	ulm_stream_if #(.W(ULM_EVT_W)) evt_in ();
	ulm_stream_if #(.W(ULM_EVT_W)) evt_out ();

	assign is_rs485 = (line_mode == ULM_MODE_RS485);
	assign is_modem = (line_mode == ULM_MODE_MODEM);
	assign is_irda  = (line_mode == ULM_MODE_IRDA);
	assign route    = ulm_route_type'(channel_routing_field);
	assign primed   = (s_q.prime == ULM_PRIME_END);

	// per-input change detection on the synchronised levels
	genvar gi;
	generate
		for (gi = 0; gi < ULM_MODEM_N; gi++) begin : g_chg
			assign chg[gi] = primed & is_modem & (s_q.sync2[gi] ^ s_q.prev[gi]);
		end
	endgenerate

	ulm_irda_filter #(
		.FILTER_W (FILTER_W),
		.BIT_W    (BIT_W)
	) u_filter (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.enable      (is_irda),
		.rx_pin      (rxd_pin),
		.filter_load (infrared_filter_setting),
		.bit_len     (bit_period_cycles),
		.demod_out   (demod)
	);

	assign evt_in.valid  = s_q.pend_v;
	assign evt_in.data   = {s_q.pend_chg, s_q.sync2};
	assign evt_in_ready  = evt_in.ready;
	assign evt_valid     = evt_out.valid;
	assign evt_data      = evt_out.data;
	assign evt_out.ready = evt_ready;

	ulm_fifo2 #(
		.W (ULM_EVT_W)
	) u_evt_buf (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.in_s    (evt_in),
		.out_s   (evt_out)
	);

	// infrared modulator: bit phase restarts at every transmit edge
	always_comb begin
		tx_edge   = (tx_serial != s_q.last_tx);
		pulse_len = ({2'b00, bit_period_cycles} * (BIT_W+2)'(ULM_IR_PULSE_NUM))
			>> ULM_IR_PULSE_SHIFT;
		if (tx_edge || ({2'b00, s_q.phase} + (BIT_W+2)'(1) >= {2'b00, bit_period_cycles})) begin
			ph = '0;
		end else begin
			ph = s_q.phase + 1'b1;
		end
		pulse   = ~tx_serial & ({2'b00, ph} < pulse_len);
		tx_line = is_irda ? pulse : tx_serial;
		rx_line = is_irda ? demod : rxd_pin;
	end

	always_comb begin
		s_d         = s_q;
		s_d.sync1   = {ri_pin, dsr_pin, dcd_pin, cts_pin};
		s_d.sync2   = s_q.sync1;
		s_d.prev    = s_q.sync2;
		s_d.phase   = ph;
		s_d.last_tx = tx_serial;
		s_d.ir_on   = is_irda;
		s_d.async   = is_modem;
		if (!primed) begin
			s_d.prime = s_q.prime + 1'b1;
		end

		// sticky change flags, a new change beats the read clear
		if (status_read) begin
			s_d.flags = '0;
		end
		s_d.flags = s_d.flags | chg;

		// changes gather while the buffer is full
		if (s_q.pend_v && evt_in_ready) begin
			s_d.pend_v   = 1'b0;
			s_d.pend_chg = '0;
		end
		if (|chg) begin
			s_d.pend_chg = s_d.pend_chg | chg;
			s_d.pend_v   = 1'b1;
		end

		// terminal ready, off wins when both arrive together
		if (terminal_ready_off_command) begin
			s_d.dtr = 1'b1;
		end else if (terminal_ready_on_command) begin
			s_d.dtr = 1'b0;
		end

		// clear-to-send gate changes only between characters
		if (!char_in_progress) begin
			s_d.cts_block = is_modem & s_q.sync2[ULM_IDX_CTS];
		end

		// line driver enable; framing itself is untouched in RS485
		if (is_rs485) begin
			s_d.rts = ~transmitter_drained_flag | timeguard_active;
		end else begin
			s_d.rts = core_rts_level;
		end

		unique case (route)
			ULM_ROUTE_NORMAL: begin
				s_d.txd   = tx_line;
				s_d.rxs   = rx_line;
				s_d.rx_en = 1'b1;
				s_d.tx_en = ~s_d.cts_block;
			end
			ULM_ROUTE_ECHO: begin
				s_d.txd   = rxd_pin;
				s_d.rxs   = rx_line;
				s_d.rx_en = 1'b1;
				s_d.tx_en = ~s_d.cts_block;
			end
			ULM_ROUTE_LOCAL: begin
				s_d.txd   = ULM_TXD_IDLE;
				s_d.rxs   = tx_serial;
				s_d.rx_en = 1'b1;
				s_d.tx_en = ~s_d.cts_block;
			end
			ULM_ROUTE_REMOTE: begin
				s_d.txd   = rxd_pin;
				s_d.rxs   = ULM_RXS_IDLE;
				s_d.rx_en = 1'b0;
				s_d.tx_en = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q         <= '0;
			s_q.dtr     <= ULM_DTR_RST;
			s_q.rts     <= ULM_RTS_RST;
			s_q.txd     <= ULM_TXD_IDLE;
			s_q.rxs     <= ULM_RXS_IDLE;
			s_q.rx_en   <= 1'b1;
			s_q.tx_en   <= 1'b1;
			s_q.last_tx <= ULM_TXD_IDLE;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign txd_pin                   = s_q.txd;
	assign rts_pin                   = s_q.rts;
	assign dtr_pin                   = s_q.dtr;
	assign rx_serial                 = s_q.rxs;
	assign rx_enable                 = s_q.rx_en;
	assign tx_enable                 = s_q.tx_en;
	assign force_async               = s_q.async;
	assign infrared_active           = s_q.ir_on;
	assign ring_change_flag          = s_q.flags[ULM_IDX_RI];
	assign set_ready_change_flag     = s_q.flags[ULM_IDX_DSR];
	assign carrier_change_flag       = s_q.flags[ULM_IDX_DCD];
	assign clear_to_send_change_flag = s_q.flags[ULM_IDX_CTS];
	assign modem_levels              = s_q.sync2;
endmodule

// ### sim/ulm_modem_model.sv
`timescale 1ns/1ps
module ulm_modem_model (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [3:0] toggle,
	input  wire logic       stall,
	output logic            cts_pin,
	output logic            dsr_pin,
	output logic            dcd_pin,
	output logic            ri_pin,
	input  wire logic       evt_valid,
	input  wire logic [7:0] evt_data,
	output logic            evt_ready,
	output int              evt_count,
	output logic [7:0]      evt_last
);
	initial {ri_pin, dsr_pin, dcd_pin, cts_pin, evt_ready, evt_count, evt_last} = '0;
	// modem lines change level on request, one clock after it
	always @(posedge clk) begin
		if (sys_rst) begin
			{ri_pin, dsr_pin, dcd_pin, cts_pin} <= 4'h0;
		end else begin
			{ri_pin, dsr_pin, dcd_pin, cts_pin} <= {ri_pin, dsr_pin, dcd_pin, cts_pin} ^ toggle;
		end
		evt_ready <= !stall;
		if (evt_valid && evt_ready) begin
			evt_count <= evt_count + 1;
			evt_last <= evt_data;
		end
	end
endmodule

// ### sim/ulm_line_modes_chk.sv
`timescale 1ns/1ps
module ulm_line_modes_chk (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       clk_en,
	input wire logic [3:0] line_mode,
	input wire logic [1:0] channel_routing_field,
	input wire logic       rxd_pin,
	input wire logic       txd_pin,
	input wire logic       rts_pin,
	input wire logic       dtr_pin,
	input wire logic       cts_pin,
	input wire logic       tx_serial,
	input wire logic       transmitter_drained_flag,
	input wire logic       timeguard_active,
	input wire logic       char_in_progress,
	input wire logic       rx_serial,
	input wire logic       rx_enable,
	input wire logic       tx_enable,
	input wire logic       force_async,
	input wire logic       infrared_active,
	input wire logic       terminal_ready_on_command,
	input wire logic       terminal_ready_off_command,
	input wire logic       status_read,
	input wire logic       clear_to_send_change_flag,
	input wire logic       evt_valid,
	input wire logic [ulm_pkg::ULM_EVT_W-1:0] evt_data,
	input wire logic       evt_ready
);
	import ulm_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst || !clk_en);
	property p_rs485_rts;
		line_mode == ULM_MODE_RS485 |=>
			rts_pin == (!$past(transmitter_drained_flag) || $past(timeguard_active));
	endproperty
	a_rs485_rts: assert property (p_rs485_rts) else $error("rts wrong in rs485");
	property p_mode_flags;
		clk_en |=> force_async == ($past(line_mode) == ULM_MODE_MODEM)
			&& infrared_active == ($past(line_mode) == ULM_MODE_IRDA);
	endproperty
	a_mode_flags: assert property (p_mode_flags) else $error("mode outputs wrong");
	property p_dtr_off;
		terminal_ready_off_command |=> dtr_pin;
	endproperty
	a_dtr_off: assert property (p_dtr_off) else $error("dtr not high");
	property p_dtr_on;
		terminal_ready_on_command && !terminal_ready_off_command |=> !dtr_pin;
	endproperty
	a_dtr_on: assert property (p_dtr_on) else $error("dtr not low");
	property p_route_normal;
		channel_routing_field == ULM_ROUTE_NORMAL && line_mode != ULM_MODE_IRDA |=>
			txd_pin == $past(tx_serial) && rx_serial == $past(rxd_pin);
	endproperty
	a_route_normal: assert property (p_route_normal) else $error("normal route");
	property p_route_echo;
		channel_routing_field == ULM_ROUTE_ECHO && line_mode != ULM_MODE_IRDA |=>
			txd_pin == $past(rxd_pin) && rx_serial == $past(rxd_pin) && rx_enable;
	endproperty
	a_route_echo: assert property (p_route_echo) else $error("echo route");
	property p_route_local;
		channel_routing_field == ULM_ROUTE_LOCAL |=> txd_pin && rx_serial == $past(tx_serial);
	endproperty
	a_route_local: assert property (p_route_local) else $error("local route");
	property p_route_remote;
		channel_routing_field == ULM_ROUTE_REMOTE |=>
			txd_pin == $past(rxd_pin) && rx_serial && !rx_enable && !tx_enable;
	endproperty
	a_route_remote: assert property (p_route_remote) else $error("remote route");
	property p_cts_flag;
		line_mode == ULM_MODE_MODEM && $changed(cts_pin) |-> ##[2:5] clear_to_send_change_flag;
	endproperty
	a_cts_flag: assert property (p_cts_flag) else $error("cts change missed");
	property p_cts_gate;
		char_in_progress && tx_enable && channel_routing_field != ULM_ROUTE_REMOTE |=> tx_enable;
	endproperty
	a_cts_gate: assert property (p_cts_gate) else $error("tx cut mid character");
	property p_flag_stand;
		clear_to_send_change_flag && !status_read |=> clear_to_send_change_flag;
	endproperty
	a_flag_stand: assert property (p_flag_stand) else $error("flag lost unread");
	property p_evt_hold;
		evt_valid && !evt_ready |=> evt_valid && $stable(evt_data);
	endproperty
	a_evt_hold: assert property (p_evt_hold) else $error("event word not held");
endmodule
bind ulm_line_modes ulm_line_modes_chk u_chk (
	.clk, .sys_rst, .clk_en, .line_mode, .channel_routing_field, .rxd_pin, .txd_pin,
	.rts_pin, .dtr_pin, .cts_pin, .tx_serial, .transmitter_drained_flag, .timeguard_active,
	.char_in_progress, .rx_serial, .rx_enable, .tx_enable, .force_async, .infrared_active,
	.terminal_ready_on_command, .terminal_ready_off_command, .status_read,
	.clear_to_send_change_flag, .evt_valid, .evt_data, .evt_ready
);

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import ulm_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        clk_en = 1'b1;
	logic [3:0]  line_mode = 4'h0;
	logic [1:0]  channel_routing_field = 2'h0;
	logic [7:0]  infrared_filter_setting = 8'h06;
	logic [15:0] bit_period_cycles = 16'h0014;
	logic        rxd_pin = 1'b1, tx_serial = 1'b1, transmitter_drained_flag = 1'b1;
	logic        timeguard_active = 1'b0, char_in_progress = 1'b0, core_rts_level = 1'b0;
	logic        terminal_ready_on_command = 1'b0, terminal_ready_off_command = 1'b0;
	logic        status_read = 1'b0, stall = 1'b0;
	logic [3:0]  toggle = 4'h0, exp, modem_levels;
	logic        txd_pin, rts_pin, dtr_pin, cts_pin, dsr_pin, dcd_pin, ri_pin, rx_serial;
	logic        rx_enable, tx_enable, force_async, infrared_active, evt_valid, evt_ready;
	logic        ring_change_flag, set_ready_change_flag, carrier_change_flag;
	logic        clear_to_send_change_flag;
	logic [7:0]  evt_data, evt_last;
	int          evt_count, i, n, m;
	int          error_cnt = 0;
	int          check_count = 0;
	always #2 clk = ~clk;
	ulm_line_modes dut (
		.clk, .sys_rst, .clk_en, .line_mode, .channel_routing_field, .infrared_filter_setting,
		.bit_period_cycles, .rxd_pin, .txd_pin, .rts_pin, .dtr_pin, .cts_pin, .dsr_pin, .dcd_pin,
		.ri_pin, .tx_serial, .transmitter_drained_flag, .timeguard_active, .char_in_progress,
		.core_rts_level, .rx_serial, .rx_enable, .tx_enable, .force_async, .infrared_active,
		.terminal_ready_on_command, .terminal_ready_off_command, .status_read, .ring_change_flag,
		.set_ready_change_flag, .carrier_change_flag, .clear_to_send_change_flag, .modem_levels,
		.evt_valid, .evt_data, .evt_ready
	);
	ulm_modem_model partner (
		.clk, .sys_rst, .toggle, .stall, .cts_pin, .dsr_pin, .dcd_pin, .ri_pin, .evt_valid,
		.evt_data, .evt_ready, .evt_count, .evt_last
	);
	task automatic step(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	task automatic finish_test;
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
	initial begin
		step(20);
		sys_rst = 1'b0;
		step(4);
		check({txd_pin, rx_serial, rx_enable, tx_enable, dtr_pin, rts_pin}, 8'h3e);
		for (i = 0; i < 8; i++) begin
			channel_routing_field = i[2:1];
			rxd_pin = i[0];
			tx_serial = ~i[0];
			step(2);
			case (i[2:1])
				2'h0: exp = {~i[0], i[0], 2'h3};
				2'h1: exp = {i[0], i[0], 2'h3};
				2'h2: exp = {1'b1, ~i[0], 2'h3};
				default: exp = {i[0], 1'b1, 2'h0};
			endcase
			check({txd_pin, rx_serial, rx_enable, tx_enable}, exp);
		end
		channel_routing_field = 2'h0;
		{rxd_pin, tx_serial, core_rts_level} = 3'h7;
		step(2);
		check(rts_pin, 8'h01);
		line_mode = ULM_MODE_RS485;
		for (i = 0; i < 4; i++) begin
			{timeguard_active, transmitter_drained_flag} = i[1:0];
			step(2);
			check(rts_pin, {7'h00, ~i[0] | i[1]});
		end
		{timeguard_active, transmitter_drained_flag} = 2'h1;
		line_mode = ULM_MODE_MODEM;
		step(2);
		check(force_async, 8'h01);
		terminal_ready_on_command = 1'b1;
		step(1);
		terminal_ready_on_command = 1'b0;
		step(1);
		check(dtr_pin, 8'h00);
		{terminal_ready_on_command, terminal_ready_off_command} = 2'h3;
		step(1);
		{terminal_ready_on_command, terminal_ready_off_command} = 2'h0;
		step(1);
		check(dtr_pin, 8'h01);
		stall = 1'b1;
		for (i = 0; i < 4; i++) begin
			toggle = 4'h1 << i;
			step(1);
			toggle = 4'h0;
			step(6);
			check({ring_change_flag, set_ready_change_flag, carrier_change_flag,
				clear_to_send_change_flag}, (8'h2 << i) - 8'h1);
		end
		check(modem_levels, 8'h0f);
		stall = 1'b0;
		step(8);
		check(8'(evt_count), 8'h03);
		check(evt_last, 8'hcf);
		status_read = 1'b1;
		step(1);
		status_read = 1'b0;
		step(1);
		check({ring_change_flag, set_ready_change_flag, carrier_change_flag,
			clear_to_send_change_flag}, 8'h00);
		check(tx_enable, 8'h00);
		for (i = 0; i < 2; i++) begin
			toggle = 4'h1;
			char_in_progress = i[0];
			step(1);
			toggle = 4'h0;
			step(6);
			check(tx_enable, 8'h01);
		end
		char_in_progress = 1'b0;
		step(2);
		check(tx_enable, 8'h00);
		line_mode = ULM_MODE_IRDA;
		step(3);
		check(infrared_active, 8'h01);
		rxd_pin = 1'b0;
		step(4);
		rxd_pin = 1'b1;
		step(1);
		rxd_pin = 1'b0;
		n = 0;
		while (rx_serial !== 1'b0 && n < 30) begin
			step(1);
			n++;
		end
		rxd_pin = 1'b1;
		check(n >= 7 && n <= 11, 8'h01);
		m = 0;
		while (rx_serial === 1'b0 && m < 60) begin
			step(1);
			m++;
		end
		check(8'(m), 8'h14);
		for (i = 0; i < 2; i++) begin
			tx_serial = i[0];
			step(4 * i);
			n = 0;
			repeat (18) begin
				step(1);
				if (txd_pin === 1'b1) n++;
			end
			check(8'(n), i[0] ? 8'h00 : 8'h03);
		end
		clk_en = 1'b0;
		line_mode = ULM_MODE_NORMAL;
		step(3);
		check(infrared_active, 8'h01);
		check(txd_pin, 8'h00);
		clk_en = 1'b1;
		step(2);
		check(infrared_active, 8'h00);
		check(txd_pin, 8'h01);
		finish_test();
	end
endmodule
